/* include/ild_map.svh */
// Register offsets, field positions and reset values of the lookup decode
// Behaviour
// - Two-input upper: pin 6 from table bits 7:4
// - Two-input lower: pin 2 from table bits 3:0
// - Three-input upper: pin 7 from second table
// - Upper nibble acts only in two-input upper mode
// - Lower nibble acts only in two-input lower mode
// - Second table acts only in three-input mode
// - Upper mode 00 leaves pins 7:4 plain
// - Upper mode 01 decodes pin 6 from 5:4
// - Upper mode 10 decodes pin 7 from 6:4
// - Lower mode 01 decodes pin 2 from 1:0
`ifndef ILD_MAP_SVH
`define ILD_MAP_SVH

// ==========================================================================
// Register offsets
`define ILD_ADDR_MODE 8'h10
`define ILD_ADDR_TBL0 8'h11
`define ILD_ADDR_TBL1 8'h12

// ==========================================================================
// Reset values
`define ILD_RST_MODE 8'h00
`define ILD_RST_TBL 8'h00
`define ILD_RD_UNMAPPED 8'h00

// ==========================================================================
// Mode register fields
`define ILD_MODE_HI_MSB 5
`define ILD_MODE_HI_LSB 4
`define ILD_MODE_LO_MSB 1
`define ILD_MODE_LO_LSB 0

// ==========================================================================
// Mode encodings
`define ILD_MODE_OFF_VAL 2'h0
`define ILD_MODE_TWO_VAL 2'h1
`define ILD_MODE_THREE_VAL 2'h2
`define ILD_MODE_SPLIT_VAL 2'h3

`endif

/* include/ild_pkg.sv */
// Types shared by the lookup decode files
`include "ild_map.svh"
`default_nettype none

package ild_pkg;

    // Logic mode of one pin half, binary count along off, two-input, three-input
    typedef enum logic [1:0] {
        ILD_MODE_OFF = `ILD_MODE_OFF_VAL,
        ILD_MODE_TWO = `ILD_MODE_TWO_VAL,
        ILD_MODE_THREE = `ILD_MODE_THREE_VAL,
        ILD_MODE_SPLIT = `ILD_MODE_SPLIT_VAL
    } ild_mode_e;

    typedef logic [7:0] ild_byte_t;

endpackage

`default_nettype wire

/* logic/ild_regs.sv */
// Mode and lookup table registers behind the serial register port
`include "ild_map.svh"
`default_nettype none

module ild_regs (
    input wire logic clk, // 20 MHz device clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic reg_wr_en, // Write strobe from the serial port
    input wire ild_pkg::ild_byte_t reg_addr, // Register address
    input wire ild_pkg::ild_byte_t reg_wdata, // Write data
    output ild_pkg::ild_byte_t reg_rdata, // Read data of reg_addr
    output logic reg_hit, // Address is one of ours
    output ild_pkg::ild_mode_e mode_hi, // upper_half_logic_mode
    output ild_pkg::ild_mode_e mode_lo, // lower_half_logic_mode
    output ild_pkg::ild_byte_t tbl0, // two_input_lookup_table
    output ild_pkg::ild_byte_t tbl1 // upper_three_input_lookup_table
);
    import ild_pkg::*;

    ild_byte_t mode_reg;
    ild_byte_t next_rdata;
    logic hit_mode;
    logic hit_tbl0;
    logic hit_tbl1;

    // Address decode
    assign hit_mode = reg_addr == `ILD_ADDR_MODE;
    assign hit_tbl0 = reg_addr == `ILD_ADDR_TBL0;
    assign hit_tbl1 = reg_addr == `ILD_ADDR_TBL1;
    assign reg_hit = hit_mode | hit_tbl0 | hit_tbl1;

    // Readback; reserved mode bits and unmapped addresses read zero
    assign next_rdata = hit_mode ? mode_reg :
                        hit_tbl0 ? tbl0 :
                        hit_tbl1 ? tbl1 : `ILD_RD_UNMAPPED;

    // Only the two mode fields are stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= `ILD_RST_MODE;
        end else if (reg_wr_en && hit_mode) begin
            mode_reg <= `ILD_RST_MODE;
            mode_reg[`ILD_MODE_HI_MSB:`ILD_MODE_HI_LSB] <=
                reg_wdata[`ILD_MODE_HI_MSB:`ILD_MODE_HI_LSB];
            mode_reg[`ILD_MODE_LO_MSB:`ILD_MODE_LO_LSB] <=
                reg_wdata[`ILD_MODE_LO_MSB:`ILD_MODE_LO_LSB];
        end
    end

    // Lookup tables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tbl0 <= `ILD_RST_TBL;
            tbl1 <= `ILD_RST_TBL;
        end else begin
            if (reg_wr_en && hit_tbl0) tbl0 <= reg_wdata;
            if (reg_wr_en && hit_tbl1) tbl1 <= reg_wdata;
        end
    end

    // Registered read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `ILD_RD_UNMAPPED;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    assign mode_hi = ild_mode_e'(mode_reg[`ILD_MODE_HI_MSB:`ILD_MODE_HI_LSB]);
    assign mode_lo = ild_mode_e'(mode_reg[`ILD_MODE_LO_MSB:`ILD_MODE_LO_LSB]);

endmodule // ild_regs

`default_nettype wire

/* logic/ild_decode.sv */
// Programmable lookup decode of the expander pins, with its registers
`include "ild_map.svh"
`default_nettype none

module ild_decode (
    input wire logic clk, // 20 MHz device clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic reg_wr_en, // Write strobe from the serial port
    input wire ild_pkg::ild_byte_t reg_addr, // Register address
    input wire ild_pkg::ild_byte_t reg_wdata, // Write data
    output ild_pkg::ild_byte_t reg_rdata, // Read data, one cycle later
    output logic reg_hit, // Address decodes to a register
    input wire ild_pkg::ild_byte_t pin_in, // Sampled pin levels 7:0
    output ild_pkg::ild_byte_t dec_out, // Decoded pin values
    output ild_pkg::ild_byte_t dec_drive // Pin taken over by decode
);
    import ild_pkg::*;

    // ======================================================================
    // Helpers

    // Pick one bit of a four-entry table by a two-bit index
    function automatic logic lut4(input logic [3:0] tbl,
                                  input logic [1:0] idx);
        lut4 = tbl[idx];
    endfunction

    // ======================================================================
    // Registers

    ild_mode_e mode_hi;
    ild_mode_e mode_lo;
    ild_byte_t tbl0;
    ild_byte_t tbl1;

    ild_regs u_regs (
        .clk(clk),
        .rst(rst),
        .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_hit(reg_hit),
        .mode_hi(mode_hi),
        .mode_lo(mode_lo),
        .tbl0(tbl0),
        .tbl1(tbl1)
    );

    // ======================================================================
    // Decode

    logic sel_two_hi;
    logic sel_three_hi;
    logic sel_two_lo;
    logic lut_hi;
    logic lut_lo;
    logic lut_three;
    ild_byte_t next_dec_out;
    ild_byte_t next_dec_drive;

    // Mode selection; off and reserved codes take no pin
    assign sel_two_hi = mode_hi == ILD_MODE_TWO;
    assign sel_three_hi = mode_hi == ILD_MODE_THREE;
    assign sel_two_lo = mode_lo == ILD_MODE_TWO;

    // Table lookups, recomputed every cycle from live pins
    assign lut_hi = lut4(tbl0[7:4], pin_in[5:4]);
    assign lut_lo = lut4(tbl0[3:0], pin_in[1:0]);
    assign lut_three = tbl1[pin_in[6:4]];

    // Pin 7 three-input, pin 6 and pin 2 two-input, others plain
    assign next_dec_drive = {sel_three_hi, sel_two_hi, 3'h0,
                             sel_two_lo, 2'h0};
    assign next_dec_out = {sel_three_hi & lut_three, sel_two_hi & lut_hi,
                           3'h0, sel_two_lo & lut_lo, 2'h0};

    // Output flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dec_out <= `ILD_RST_TBL;
            dec_drive <= `ILD_RST_TBL;
        end else begin
            dec_out <= next_dec_out;
            dec_drive <= next_dec_drive;
        end
    end

    // ======================================================================
    // Assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Pin 6 follows upper nibble entry picked by pins 5:4
    property p_two_hi_value;
        (mode_hi == ILD_MODE_TWO) |=>
            dec_out[6] == $past(tbl0[{1'b1, pin_in[5:4]}]);
    endproperty
    a_two_hi_value: assert property (p_two_hi_value)
        else $error("pin 6 decode value wrong");

    // Pin 2 follows lower nibble entry picked by pins 1:0
    property p_two_lo_value;
        (mode_lo == ILD_MODE_TWO) |=>
            dec_out[2] == $past(tbl0[{1'b0, pin_in[1:0]}]);
    endproperty
    a_two_lo_value: assert property (p_two_lo_value)
        else $error("pin 2 decode value wrong");

    // Pin 7 follows second table entry picked by pins 6:4
    property p_three_value;
        (mode_hi == ILD_MODE_THREE) |=>
            dec_out[7] == $past(tbl1[pin_in[6:4]]);
    endproperty
    a_three_value: assert property (p_three_value)
        else $error("pin 7 decode value wrong");

    // Upper nibble has no effect outside two-input upper mode
    property p_hi_nibble_idle;
        (mode_hi != ILD_MODE_TWO) |=> !dec_drive[6] && !dec_out[6];
    endproperty
    a_hi_nibble_idle: assert property (p_hi_nibble_idle)
        else $error("pin 6 driven outside two-input mode");

    // Lower nibble has no effect outside two-input lower mode
    property p_lo_nibble_idle;
        (mode_lo != ILD_MODE_TWO) |=> !dec_drive[2] && !dec_out[2];
    endproperty
    a_lo_nibble_idle: assert property (p_lo_nibble_idle)
        else $error("pin 2 driven outside two-input mode");

    // Second table has no effect outside three-input mode
    property p_three_idle;
        (mode_hi != ILD_MODE_THREE) |=> !dec_drive[7] && !dec_out[7];
    endproperty
    a_three_idle: assert property (p_three_idle)
        else $error("pin 7 driven outside three-input mode");

    // Mode off leaves the whole upper half plain
    property p_hi_off;
        (mode_hi == ILD_MODE_OFF) |=> dec_drive[7:4] == 4'h0;
    endproperty
    a_hi_off: assert property (p_hi_off)
        else $error("upper pins taken while decode off");

    // Two-input upper mode takes pin 6 only
    property p_hi_two_drive;
        (mode_hi == ILD_MODE_TWO) |=>
            dec_drive[7:4] == 4'h4;
    endproperty
    a_hi_two_drive: assert property (p_hi_two_drive)
        else $error("two-input upper mode drives wrong pins");

    // Three-input mode takes pin 7 only
    property p_hi_three_drive;
        (mode_hi == ILD_MODE_THREE) |=>
            dec_drive[7:4] == 4'h8;
    endproperty
    a_hi_three_drive: assert property (p_hi_three_drive)
        else $error("three-input mode drives wrong pins");

    // Two-input lower mode takes pin 2 only
    property p_lo_two_drive;
        (mode_lo == ILD_MODE_TWO) |=> dec_drive[3:0] == 4'h4;
    endproperty
    a_lo_two_drive: assert property (p_lo_two_drive)
        else $error("two-input lower mode drives wrong pins");

    // Index change alone, with mode held, updates pin 6 one cycle later
    property p_follow_index;
        (mode_hi == ILD_MODE_TWO) ##1
        ((mode_hi == ILD_MODE_TWO) && !reg_wr_en &&
         $changed(pin_in[5:4]))
        |=> dec_out[6] == $past(tbl0[{1'b1, pin_in[5:4]}]);
    endproperty
    a_follow_index: assert property (p_follow_index)
        else $error("pin 6 did not follow index change");

    // Table write reaches pin 2 within two cycles with pins held
    property p_follow_table;
        (mode_lo == ILD_MODE_TWO && reg_wr_en &&
         reg_addr == `ILD_ADDR_TBL0) ##1
        ($stable(pin_in[1:0]) && mode_lo == ILD_MODE_TWO)
        |=> dec_out[2] == $past(tbl0[{1'b0, pin_in[1:0]}]);
    endproperty
    a_follow_table: assert property (p_follow_table)
        else $error("pin 2 did not follow table write");

    // ======================================================================
    // Coverage

    property p_cov_two_hi;
        mode_hi == ILD_MODE_TWO ##1 dec_out[6];
    endproperty
    c_cov_two_hi: cover property (p_cov_two_hi);

    property p_cov_two_lo;
        mode_lo == ILD_MODE_TWO ##1 dec_out[2];
    endproperty
    c_cov_two_lo: cover property (p_cov_two_lo);

    property p_cov_three;
        mode_hi == ILD_MODE_THREE && pin_in[6:4] == 3'h7 ##1 dec_out[7];
    endproperty
    c_cov_three: cover property (p_cov_three);

    property p_cov_switch;
        mode_hi == ILD_MODE_TWO ##1 mode_hi == ILD_MODE_THREE;
    endproperty
    c_cov_switch: cover property (p_cov_switch);

endmodule // ild_decode

`default_nettype wire

/* test/ild_pin_model.sv */
// Pin pads around the lookup decode: the decode wins where it drives
`default_nettype none

module ild_pin_model (
    input wire logic [7:0] ext_lvl, // Level applied from outside
    input wire logic [7:0] dec_out, // Decoded values
    input wire logic [7:0] dec_drive, // Pins owned by the decode
    output logic [7:0] pin_lvl // Level seen on the pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // Owned pins show the decoded value, the others the outside level
    assign pin_lvl = (dec_drive & dec_out) | (~dec_drive & ext_lvl);
endmodule // ild_pin_model

`default_nettype wire

/* test/test_io_lookup_decode_logic.sv */
// Self-checking bench of the lookup decode and its registers
`include "ild_map.svh"
`default_nettype none

module test_io_lookup_decode_logic;
    timeunit 1ns;
    timeprecision 1ns;
    import ild_pkg::*;
    typedef struct {int due; logic [15:0] val; string what;} ild_note_s;

    // ======================================================================
    // Signals and bench state
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr_en = 1'b0;
    ild_byte_t reg_addr = 8'h00;
    ild_byte_t reg_wdata = 8'h00;
    ild_byte_t reg_rdata;
    logic reg_hit;
    ild_byte_t pin_in;
    ild_byte_t dec_out;
    ild_byte_t dec_drive;
    ild_byte_t ext_lvl = 8'h00;
    ild_note_s notes[$];
    int ncyc = 0;
    int cyc = 0;
    int bad_count = 0;
    int compares = 0;
    logic [31:0] seed = 32'h0000_2943;
    logic [31:0] r;
    logic [15:0] got;
    logic [1:0] hi = 2'h0;
    logic [1:0] lo = 2'h0;
    ild_byte_t t0 = 8'h00;
    ild_byte_t t1 = 8'h00;
    ild_byte_t last;

    ild_decode u_ild_decode (
        .clk(clk),
        .rst(rst),
        .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_hit(reg_hit),
        .pin_in(pin_in),
        .dec_out(dec_out),
        .dec_drive(dec_drive)
    );

    ild_pin_model u_ild_pin_model (
        .ext_lvl(ext_lvl),
        .dec_out(dec_out),
        .dec_drive(dec_drive),
        .pin_lvl(pin_in)
    );

    // Clock, 50 ns period
    always #25 clk = ~clk;

    // ======================================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic note(input logic [15:0] v, input string w);
        notes.push_back('{ncyc + 2, v, w});
    endtask

    // One register write, strobe high for one cycle
    task automatic wr(input ild_byte_t a, input ild_byte_t d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        if (a == `ILD_ADDR_MODE) begin
            hi = d[5:4];
            lo = d[1:0];
        end
        if (a == `ILD_ADDR_TBL0) t0 = d;
        if (a == `ILD_ADDR_TBL1) t1 = d;
    endtask

    // Read one address, data due one edge later with the hit flag
    task automatic rd(input ild_byte_t a, input ild_byte_t e, input logic h);
        @(posedge clk);
        reg_addr <= a;
        note({7'h00, h, e}, "read");
        @(posedge clk);
    endtask

    // Apply pins and note the decode expected one edge later
    task automatic chk(input ild_byte_t p);
        ild_byte_t d;
        ild_byte_t o;
        d = 8'h00;
        o = 8'h00;
        d[6] = (hi == 2'h1);
        o[6] = d[6] & t0[4 + p[5:4]];
        d[7] = (hi == 2'h2);
        o[7] = d[7] & t1[p[6:4]];
        d[2] = (lo == 2'h1);
        o[2] = d[2] & t0[p[1:0]];
        last = p;
        @(posedge clk);
        ext_lvl <= p;
        note({d, o}, "decode");
        @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ======================================================================
    // Monitor: takes due notes off the queue and compares
    always @(negedge clk) begin
        ncyc++;
        while (notes.size() > 0 && notes[0].due <= ncyc) begin
            compares++;
            if (notes[0].what == "read") got = {7'h00, reg_hit, reg_rdata};
            else got = {dec_drive, dec_out};
            if (got !== notes[0].val) begin
                bad_count++;
                $display("unexpected at %0t: %s got %h want %h", $time,
                         notes[0].what, got, notes[0].val);
            end
            void'(notes.pop_front());
        end
    end

    // Cycle ceiling against a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            $display("unexpected at %0t: timeout", $time);
            wrap_up();
        end
    end

    // ======================================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(`ILD_ADDR_MODE, 8'h00, 1'b1);
        rd(`ILD_ADDR_TBL0, 8'h00, 1'b1);
        rd(`ILD_ADDR_TBL1, 8'h00, 1'b1);
        wr(8'h13, 8'hFF);
        wr(8'h0F, 8'hFF);
        rd(8'h13, 8'h00, 1'b0);
        rd(`ILD_ADDR_TBL0, 8'h00, 1'b1);
        chk(8'hFF);
        $display("test reset and unmapped done");
        wr(`ILD_ADDR_MODE, 8'hFF);
        rd(`ILD_ADDR_MODE, 8'h33, 1'b1);
        r = rnd();
        wr(`ILD_ADDR_TBL0, r[7:0]);
        wr(`ILD_ADDR_TBL1, r[15:8]);
        rd(`ILD_ADDR_TBL0, r[7:0], 1'b1);
        rd(`ILD_ADDR_TBL1, r[15:8], 1'b1);
        $display("test register access done");
        for (int m = 0; m < 16; m++) begin
            r = rnd();
            wr(`ILD_ADDR_TBL0, r[7:0]);
            wr(`ILD_ADDR_TBL1, r[15:8]);
            wr(`ILD_ADDR_MODE, {2'b00, m[3:2], 2'b00, m[1:0]});
            for (int p = 0; p < 8; p++) begin
                r = rnd();
                chk({r[7], p[2:0], r[3:2], p[1:0]});
            end
            wr(`ILD_ADDR_TBL0, ~t0);
            chk(last);
            wr(`ILD_ADDR_TBL1, ~t1);
            chk(last);
        end
        $display("test mode sweep done");
        // Reset in mid-run clears modes and tables again
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        hi = 2'h0;
        lo = 2'h0;
        t0 = `ILD_RST_TBL;
        t1 = `ILD_RST_TBL;
        rd(`ILD_ADDR_MODE, `ILD_RST_MODE, 1'b1);
        rd(`ILD_ADDR_TBL1, `ILD_RST_TBL, 1'b1);
        chk(8'hFF);
        $display("test mid-run reset done");
        repeat (3) @(posedge clk);
        wrap_up();
    end
endmodule // test_io_lookup_decode_logic

`default_nettype wire
